// >>> boot_strap_latch.sv
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Function
// [R01] sample all strap pins at reset release
// [R02] board holds straps stable before reset release
// [R03] bits 2..0 give reference oscillator frequency
// [R04] bits 6..3 select primary boot source
// [R05] bits 9..7 are primary source options
// [R06] bits 12..10 select backup boot source
// [R07] bit 13 is backup source option
// [R08] bit 14 reserved, no meaning
// [R09] bit 15 requests power-on self-test
// [R10] primary failure falls back to backup
// [R11] after latch, pins go to alternate use
// [R12] drivers restore straps on every reset output
// [R13] captured word frozen until next reset
module boot_strap_latch
	import strap_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [strap_pkg::strap_width-1:0] boot_strap_pins,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [strap_pkg::pll_ref_w-1:0] pll_ref_sel,
	output logic [strap_pkg::prim_src_w-1:0] primary_src,
	output logic [strap_pkg::prim_opt_w-1:0] primary_opt,
	output logic [strap_pkg::back_src_w-1:0] backup_src,
	output logic backup_opt,
	output logic power_on_self_test,
	output logic pins_released,
	output logic power_on_self_test_running,
	output logic boot_use_backup
);
	//------------------------------------------------
	// capture
	//------------------------------------------------
	logic [strap_width-1:0] cfg_word;
	logic latched;

	strap_capture #(.width(strap_width)) u_cap (
		.pclk(pclk),
		.presetn(presetn),
		.boot_strap_pins(boot_strap_pins),
		.cfg_word_ff(cfg_word),
		.latched_ff(latched)
	);

	//------------------------------------------------
	// apb control pulses into sequencer
	//------------------------------------------------
	logic wr_ctrl;
	logic prim_fail_ff, power_on_self_test_done_ff;
	logic nxt_prim_fail, nxt_power_on_self_test_done;
	logic seq_power_on_self_test, seq_back, seq_fail;

	assign wr_ctrl = psel & penable & pwrite & (paddr == boot_ctrl_off);

	always_comb begin
		nxt_prim_fail = wr_ctrl & pwdata[ctrl_prim_fail_bit];
		nxt_power_on_self_test_done = wr_ctrl & pwdata[ctrl_power_on_self_test_done_bit];
	end

	boot_sequencer u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.latched(latched),
		.power_on_self_test_req(cfg_word[power_on_self_test_bit]),
		.power_on_self_test_done(power_on_self_test_done_ff),
		.prim_fail(prim_fail_ff),
		.power_on_self_test_run_ff(seq_power_on_self_test),
		.use_backup_ff(seq_back),
		.fail_seen_ff(seq_fail)
	);

	//------------------------------------------------
	// decoded field outputs, registered
	//------------------------------------------------
	logic [pll_ref_w-1:0] nxt_pll;
	logic [prim_src_w-1:0] nxt_psrc;
	logic [prim_opt_w-1:0] nxt_popt;
	logic [back_src_w-1:0] nxt_bsrc;
	logic nxt_bopt, nxt_power_on_self_test, nxt_rel;

	always_comb begin
		nxt_pll = cfg_word[pll_ref_lsb +: pll_ref_w]; // see [R03]
		nxt_psrc = cfg_word[prim_src_lsb +: prim_src_w]; // see [R04]
		nxt_popt = cfg_word[prim_opt_lsb +: prim_opt_w]; // see [R05]
		nxt_bsrc = cfg_word[back_src_lsb +: back_src_w]; // see [R06]
		nxt_bopt = cfg_word[back_opt_bit]; // see [R07]
		// bit 14 is readable in the word but drives nothing, see [R08]
		nxt_power_on_self_test = cfg_word[power_on_self_test_bit]; // see [R09]
		nxt_rel = latched; // see [R11]
	end

	//------------------------------------------------
	// apb read path; zero-wait slave
	//------------------------------------------------
	logic [31:0] nxt_prdata;
	logic nxt_slverr;
	logic setup;

	assign setup = psel & ~penable;

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_slverr = 1'b0;
		if (setup) begin
			unique case (paddr)
				cfg_word_off: nxt_prdata[strap_width-1:0] = cfg_word;
				boot_ctrl_off: nxt_prdata = 32'h0000_0000;
				boot_stat_off: begin
					nxt_prdata[stat_latched_bit] = latched;
					nxt_prdata[stat_use_backup_bit] = seq_back;
					nxt_prdata[stat_power_on_self_test_run_bit] = seq_power_on_self_test;
					nxt_prdata[stat_fail_seen_bit] = seq_fail;
				end
				default: nxt_slverr = 1'b1;
			endcase
			// config word is read only
			if (pwrite && paddr == cfg_word_off) begin
				nxt_slverr = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prim_fail_ff <= 1'b0;
			power_on_self_test_done_ff <= 1'b0;
			pll_ref_sel <= '0;
			primary_src <= '0;
			primary_opt <= '0;
			backup_src <= '0;
			backup_opt <= 1'b0;
			power_on_self_test <= 1'b0;
			pins_released <= 1'b0;
			power_on_self_test_running <= 1'b0;
			boot_use_backup <= 1'b0;
		end else begin
			// pready rises in the access cycle, falls after it
			pready <= setup;
			pslverr <= nxt_slverr;
			if (setup) begin
				prdata <= nxt_prdata;
			end
			prim_fail_ff <= nxt_prim_fail;
			power_on_self_test_done_ff <= nxt_power_on_self_test_done;
			pll_ref_sel <= nxt_pll;
			primary_src <= nxt_psrc;
			primary_opt <= nxt_popt;
			backup_src <= nxt_bsrc;
			backup_opt <= nxt_bopt;
			power_on_self_test <= nxt_power_on_self_test;
			pins_released <= nxt_rel;
			power_on_self_test_running <= seq_power_on_self_test;
			boot_use_backup <= seq_back;
		end
	end

	property p_release;
		@(posedge pclk) disable iff (!presetn)
		$rose(latched) |=> pins_released;
	endproperty
	a_release: assert property (p_release) // see [R11]
		else $error("pins not released after latch");

	property p_fields;
		@(posedge pclk) disable iff (!presetn)
		latched |=> pll_ref_sel == $past(cfg_word[2:0])
			&& primary_src == $past(cfg_word[6:3])
			&& primary_opt == $past(cfg_word[9:7]);
	endproperty
	a_fields: assert property (p_fields) // see [R03]
		else $error("primary field decode wrong");

	property p_back_fields;
		@(posedge pclk) disable iff (!presetn)
		latched |=> backup_src == $past(cfg_word[12:10])
			&& backup_opt == $past(cfg_word[13])
			&& power_on_self_test == $past(cfg_word[15]);
	endproperty
	a_back_fields: assert property (p_back_fields) // see [R06]
		else $error("backup field decode wrong");

	//------------------------------------------------
	// bus and sequencing checks
	//------------------------------------------------
	// one setup cycle, answered in the very next cycle, then idle again
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		s_setup |=> s_answer;
	endproperty
	a_ready: assert property (p_ready)
		else $error("apb ready timing wrong");

	property p_cfg_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == cfg_word_off)
			|=> !pslverr && prdata == 32'($past(cfg_word));
	endproperty
	a_cfg_read: assert property (p_cfg_read) // see [R01]
		else $error("config word read wrong");

	// the word comes from the straps only; software may not touch it
	property p_cfg_ro;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && pwrite && paddr == cfg_word_off) |=> pslverr;
	endproperty
	a_cfg_ro: assert property (p_cfg_ro) // see [R13]
		else $error("write to config word not refused");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr != cfg_word_off
			&& paddr != boot_ctrl_off && paddr != boot_stat_off)
			|=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");

	property p_stat_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == boot_stat_off)
			|=> !pslverr && prdata[stat_latched_bit] == $past(latched);
	endproperty
	a_stat_read: assert property (p_stat_read)
		else $error("status read wrong");

	// a control write turns into a one-cycle pulse for the sequencer;
	// the pulse costs a cycle but keeps the bus off the state decode
	sequence s_fail_write;
		psel && penable && pwrite && paddr == boot_ctrl_off
			&& pwdata[ctrl_prim_fail_bit];
	endsequence

	sequence s_done_write;
		psel && penable && pwrite && paddr == boot_ctrl_off
			&& pwdata[ctrl_power_on_self_test_done_bit];
	endsequence

	property p_fail_pulse;
		@(posedge pclk) disable iff (!presetn)
		s_fail_write |=> prim_fail_ff;
	endproperty
	a_fail_pulse: assert property (p_fail_pulse) // see [R10]
		else $error("primary failure not passed on");

	property p_done_pulse;
		@(posedge pclk) disable iff (!presetn)
		s_done_write |=> power_on_self_test_done_ff;
	endproperty
	a_done_pulse: assert property (p_done_pulse) // see [R09]
		else $error("self-test done not passed on");

	// once on the backup source there is no way back short of reset
	property p_backup_sticky;
		@(posedge pclk) disable iff (!presetn)
		boot_use_backup |=> boot_use_backup;
	endproperty
	a_backup_sticky: assert property (p_backup_sticky) // see [R10]
		else $error("backup selection dropped");

	property p_release_holds;
		@(posedge pclk) disable iff (!presetn)
		pins_released |=> pins_released;
	endproperty
	a_release_holds: assert property (p_release_holds) // see [R11]
		else $error("pins taken back after release");

	// the pins carry other traffic now, the decode must not follow it
	property p_frozen_fields;
		@(posedge pclk) disable iff (!presetn)
		pins_released |=> $stable(pll_ref_sel) && $stable(primary_src)
			&& $stable(primary_opt) && $stable(backup_src)
			&& $stable(backup_opt) && $stable(power_on_self_test);
	endproperty
	a_frozen_fields: assert property (p_frozen_fields) // see [R13]
		else $error("decoded fields moved after latch");

	property p_power_on_self_test_only_on_req;
		@(posedge pclk) disable iff (!presetn)
		(pins_released && !power_on_self_test) |-> !power_on_self_test_running;
	endproperty
	a_power_on_self_test_only_on_req: assert property (p_power_on_self_test_only_on_req) // see [R09]
		else $error("self-test running without request");
endmodule
`default_nettype wire

// >>> strap_pkg.sv
`default_nettype none
package strap_pkg;
	localparam int strap_width = 16;
	// field positions of the captured configuration word
	localparam int pll_ref_lsb = 0;
	localparam int pll_ref_w = 3;
	localparam int prim_src_lsb = 3;
	localparam int prim_src_w = 4;
	localparam int prim_opt_lsb = 7;
	localparam int prim_opt_w = 3;
	localparam int back_src_lsb = 10;
	localparam int back_src_w = 3;
	localparam int back_opt_bit = 13;
	localparam int rsvd_bit = 14;
	localparam int power_on_self_test_bit = 15;
	// apb register byte offsets
	localparam logic [11:0] cfg_word_off = 12'h000;
	localparam logic [11:0] boot_ctrl_off = 12'h004;
	localparam logic [11:0] boot_stat_off = 12'h008;
	// boot_ctrl / boot_stat bits
	localparam int ctrl_prim_fail_bit = 0;
	localparam int ctrl_power_on_self_test_done_bit = 1;
	localparam int stat_latched_bit = 0;
	localparam int stat_use_backup_bit = 1;
	localparam int stat_power_on_self_test_run_bit = 2;
	localparam int stat_fail_seen_bit = 3;
	localparam logic [15:0] cfg_reset_val = 16'h0000;
endpackage
`default_nettype wire

// >>> strap_capture.sv
`timescale 1ns/10ps
`default_nettype none
module strap_capture
	import strap_pkg::*;
#(
	parameter int width = strap_width
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [width-1:0] boot_strap_pins,
	output logic [width-1:0] cfg_word_ff,
	output logic latched_ff
);
	logic [width-1:0] nxt_cfg_word;
	logic nxt_latched;

	always_comb begin
		nxt_cfg_word = cfg_word_ff;
		nxt_latched = 1'b1;
		// only the first edge after reset release samples the pins
		if (!latched_ff) begin
			nxt_cfg_word = boot_strap_pins; // see [R01]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_word_ff <= cfg_reset_val[width-1:0];
			latched_ff <= 1'b0;
		end else begin
			cfg_word_ff <= nxt_cfg_word;
			latched_ff <= nxt_latched;
		end
	end

	property p_word_frozen;
		@(posedge pclk) disable iff (!presetn)
		latched_ff |=> (cfg_word_ff == $past(cfg_word_ff));
	endproperty
	a_word_frozen: assert property (p_word_frozen) // see [R13]
		else $error("config word changed after latch");

	property p_sample;
		@(posedge pclk) disable iff (!presetn)
		// the release edge itself still sees reset, so it is left out
		(presetn && !latched_ff) |=> latched_ff
			&& cfg_word_ff == $past(boot_strap_pins);
	endproperty
	a_sample: assert property (p_sample) // see [R01]
		else $error("strap pins not captured");
endmodule
`default_nettype wire

// >>> boot_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module boot_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic latched,
	input wire logic power_on_self_test_req,
	input wire logic power_on_self_test_done,
	input wire logic prim_fail,
	output logic power_on_self_test_run_ff,
	output logic use_backup_ff,
	output logic fail_seen_ff
);
	typedef enum logic [3:0] {
		st_wait = 4'h1,
		st_power_on_self_test = 4'h2,
		st_prim = 4'h4,
		st_back = 4'h8
	} seq_state_t;

	seq_state_t state_ff, nxt_state;
	logic nxt_fail_seen;

	always_comb begin
		nxt_state = state_ff;
		nxt_fail_seen = fail_seen_ff | (prim_fail & state_ff == st_prim);
		unique case (state_ff)
			st_wait: begin
				if (latched) begin
					nxt_state = power_on_self_test_req ? st_power_on_self_test : st_prim; // see [R09]
				end
			end
			st_power_on_self_test: begin
				if (power_on_self_test_done) begin
					nxt_state = st_prim;
				end
			end
			st_prim: begin
				if (prim_fail) begin
					nxt_state = st_back; // see [R10]
				end
			end
			st_back: nxt_state = st_back;
			default: nxt_state = st_wait;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= st_wait;
			power_on_self_test_run_ff <= 1'b0;
			use_backup_ff <= 1'b0;
			fail_seen_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			power_on_self_test_run_ff <= (nxt_state == st_power_on_self_test);
			use_backup_ff <= (nxt_state == st_back);
			fail_seen_ff <= nxt_fail_seen;
		end
	end

	property p_fallback;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == st_prim && prim_fail) |=> use_backup_ff;
	endproperty
	a_fallback: assert property (p_fallback) // see [R10]
		else $error("no fallback to backup source");

	property p_power_on_self_test;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == st_wait && latched && power_on_self_test_req) |=> power_on_self_test_run_ff;
	endproperty
	a_power_on_self_test: assert property (p_power_on_self_test) // see [R09]
		else $error("self-test not started");
endmodule
`default_nettype wire

// >>> strap_board.sv
`timescale 1ns/10ps
`default_nettype none
module strap_board
	import strap_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pins_released,
	input wire logic [strap_width-1:0] strap_level,
	output logic [strap_width-1:0] boot_strap_pins
);
	// ----------------------------------------
	// strap resistors, then alternate use
	// ----------------------------------------
	// levels are reloaded whenever reset is low, so they are settled
	// long before release; once released the pins carry other traffic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_strap_pins <= strap_level;
		end else if (pins_released) begin
			boot_strap_pins <= ~boot_strap_pins;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import strap_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pins, lvl, v;
	logic [2:0] pll_ref_sel, primary_opt, backup_src;
	logic [3:0] primary_src;
	logic backup_opt, power_on_self_test, pins_released;
	logic power_on_self_test_running, boot_use_backup, err;
	int miscompares, samples_checked;
	logic [15:0] vals [2] = '{16'hc5a7, 16'h3a58};

	strap_board strap_board_inst (.pclk(pclk), .presetn(presetn),
		.pins_released(pins_released), .strap_level(lvl),
		.boot_strap_pins(pins));
	boot_strap_latch boot_strap_latch_inst (.pclk(pclk),
		.presetn(presetn), .boot_strap_pins(pins), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pll_ref_sel(pll_ref_sel),
		.primary_src(primary_src), .primary_opt(primary_opt),
		.backup_src(backup_src), .backup_opt(backup_opt),
		.power_on_self_test(power_on_self_test),
		.pins_released(pins_released), .power_on_self_test_running(power_on_self_test_running),
		.boot_use_backup(boot_use_backup));

	// ----------------------------------------
	// checking and verdict
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic print_verdict();
		$display("mismatches %0d of %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// apb master and bounded waits
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// sel 0 self-test flag, 1 backup flag, 2 pins released
	task automatic wait_for(input int sel, input logic want);
		for (int n = 0; n < 20; n++) begin
			@(posedge pclk);
			if ((sel == 0 ? power_on_self_test_running : sel == 1 ? boot_use_backup :
				pins_released) === want) return;
		end
		miscompares++;
		print_verdict();
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lvl = 16'h0000;
		miscompares = 0;
		samples_checked = 0;
		foreach (vals[i]) begin
			v = vals[i];
			@(posedge pclk);
			lvl <= v;
			presetn <= 1'b0;
			repeat (16) @(posedge pclk);
			check(pins_released, 1'b0, "released in reset");
			presetn <= 1'b1;
			wait_for(2, 1'b1);
			repeat (3) @(posedge pclk);
			check(pll_ref_sel, v[2:0], "pll ref");
			check(primary_src, v[6:3], "primary src");
			check(primary_opt, v[9:7], "primary opt");
			check(backup_src, v[12:10], "backup src");
			check(backup_opt, v[13], "backup opt");
			check(power_on_self_test, v[15], "self-test req");
			check(power_on_self_test_running, v[15], "self-test run");
			apb(1'b0, cfg_word_off, 32'h0);
			check(rd, {16'h0, v}, "config word");
			check(err, 1'b0, "config read accepted");
			apb(1'b0, boot_stat_off, 32'h0);
			check(rd, {29'h0, v[15], 2'b01}, "status");
			if (v[15]) begin
				apb(1'b1, boot_ctrl_off, 32'h2);
				wait_for(0, 1'b0);
			end
			check(boot_use_backup, 1'b0, "early backup");
			apb(1'b1, boot_ctrl_off, 32'h1);
			wait_for(1, 1'b1);
			apb(1'b0, boot_stat_off, 32'h0);
			check(rd, 32'h0000000b, "status after fail");
			apb(1'b1, cfg_word_off, 32'hffff);
			check(err, 1'b1, "write to config");
			apb(1'b0, cfg_word_off, 32'h0);
			check(rd, {16'h0, v}, "config kept");
			apb(1'b0, 12'h00c, 32'h0);
			check(err, 1'b1, "unmapped read");
			apb(1'b0, boot_ctrl_off, 32'h0);
			check(rd, 32'h0, "ctrl reads zero");
		end
		print_verdict();
	end
endmodule
`default_nettype wire
